// File: mtap_port.sv
// test access port controller with instruction, bypass and id registers
// assumes tck much slower than sys_clk; pins already pulled up at the pad
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - standard boundary scan controller and registers
// - port reset at power-up, idle until clocked
// - unconnected test inputs read as high
// - sample on rising, tdo and tdo_oe change on falling
// - mode select steps the controller each rise
// - data in shifts into selected register
// - undriven data input acts as one
// - output driven only when shifting
// - five high mode selects force reset
// - three-bit instruction, preset to identification
// - capture loads 01, update applies instruction
// - one-bit bypass register for every instruction other than identification
// - id code captured, shifted lsb first
module mtap_port (
  input wire logic sys_clk,
  input wire logic srst,
  input wire mtap_pkg::mtap_pins_s pins,
  output logic tdo,
  output logic tdo_oe,
  output logic [2:0] active_ins
);
  // ----------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------
  mtap_pkg::mtap_pins_s s1;
  mtap_pkg::mtap_pins_s s2;
  logic tck_d;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1 <= mtap_pkg::SYNC_RST;
      s2 <= mtap_pkg::SYNC_RST;
      tck_d <= 1'b1;
    end else begin
      s1 <= pins;
      s2 <= s1;
      tck_d <= s2.tck;
    end
  end
  wire rise = s2.tck & ~tck_d;
  wire fall = ~s2.tck & tck_d;
  wire tms = s2.tms;
  wire tdi = s2.tdi;
  // ----------------------------------------
  // controller
  // ----------------------------------------
  mtap_pkg::mtap_state_e state;
  mtap_pkg::mtap_state_e next_state;
  always_comb begin
    next_state = state;
    case (state)
      mtap_pkg::ST_RESET: next_state = tms ? mtap_pkg::ST_RESET : mtap_pkg::ST_IDLE;
      mtap_pkg::ST_IDLE: next_state = tms ? mtap_pkg::ST_SEL_DR : mtap_pkg::ST_IDLE;
      mtap_pkg::ST_SEL_DR: next_state = tms ? mtap_pkg::ST_SEL_IR : mtap_pkg::ST_CAP_DR;
      mtap_pkg::ST_CAP_DR: next_state = tms ? mtap_pkg::ST_EX1_DR : mtap_pkg::ST_SH_DR;
      mtap_pkg::ST_SH_DR: next_state = tms ? mtap_pkg::ST_EX1_DR : mtap_pkg::ST_SH_DR;
      mtap_pkg::ST_EX1_DR: next_state = tms ? mtap_pkg::ST_UPD_DR : mtap_pkg::ST_PA_DR;
      mtap_pkg::ST_PA_DR: next_state = tms ? mtap_pkg::ST_EX2_DR : mtap_pkg::ST_PA_DR;
      mtap_pkg::ST_EX2_DR: next_state = tms ? mtap_pkg::ST_UPD_DR : mtap_pkg::ST_SH_DR;
      mtap_pkg::ST_UPD_DR: next_state = tms ? mtap_pkg::ST_SEL_DR : mtap_pkg::ST_IDLE;
      mtap_pkg::ST_SEL_IR: next_state = tms ? mtap_pkg::ST_RESET : mtap_pkg::ST_CAP_IR;
      mtap_pkg::ST_CAP_IR: next_state = tms ? mtap_pkg::ST_EX1_IR : mtap_pkg::ST_SH_IR;
      mtap_pkg::ST_SH_IR: next_state = tms ? mtap_pkg::ST_EX1_IR : mtap_pkg::ST_SH_IR;
      mtap_pkg::ST_EX1_IR: next_state = tms ? mtap_pkg::ST_UPD_IR : mtap_pkg::ST_PA_IR;
      mtap_pkg::ST_PA_IR: next_state = tms ? mtap_pkg::ST_EX2_IR : mtap_pkg::ST_PA_IR;
      mtap_pkg::ST_EX2_IR: next_state = tms ? mtap_pkg::ST_UPD_IR : mtap_pkg::ST_SH_IR;
      mtap_pkg::ST_UPD_IR: next_state = tms ? mtap_pkg::ST_SEL_DR : mtap_pkg::ST_IDLE;
      default: next_state = mtap_pkg::ST_RESET;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= mtap_pkg::ST_RESET;
    end else if (rise) begin
      state <= next_state;
    end
  end
  // ----------------------------------------
  // shift registers
  // ----------------------------------------
  logic [2:0] ir_sh;
  logic [31:0] id_sh;
  logic byp;
  wire in_sh_dr = (state == mtap_pkg::ST_SH_DR);
  wire in_sh_ir = (state == mtap_pkg::ST_SH_IR);
  wire sel_byp = (active_ins != mtap_pkg::INS_IDCODE);
  wire to_tlr = (next_state == mtap_pkg::ST_RESET);
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ir_sh <= mtap_pkg::INS_IDCODE;
      active_ins <= mtap_pkg::INS_IDCODE;
      id_sh <= mtap_pkg::ID_CODE_RST;
      byp <= 1'b0;
    end else if (rise) begin
      if (to_tlr) begin
        active_ins <= mtap_pkg::INS_IDCODE;
      end
      if (state == mtap_pkg::ST_CAP_IR) begin
        ir_sh <= {active_ins[2], mtap_pkg::IR_CAPTURE};
      end else if (in_sh_ir) begin
        ir_sh <= {tdi, ir_sh[2:1]};
      end
      if (state == mtap_pkg::ST_UPD_IR) begin
        active_ins <= ir_sh;
      end
      if (state == mtap_pkg::ST_CAP_DR) begin
        id_sh <= mtap_pkg::ID_CODE_RST;
        byp <= 1'b0;
      end else if (in_sh_dr) begin
        if (sel_byp) begin
          byp <= tdi;
        end else begin
          id_sh <= {tdi, id_sh[31:1]};
        end
      end
    end
  end
  // ----------------------------------------
  // output stage, updated on falling edge
  // ----------------------------------------
  wire next_tdo = in_sh_ir ? ir_sh[0] : (sel_byp ? byp : id_sh[0]);
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (fall) begin
      tdo <= next_tdo;
      tdo_oe <= in_sh_ir | in_sh_dr;
    end
  end
  // ----------------------------------------
  // run of high mode selects seen at rises
  // ----------------------------------------
  // saturates at four; the next high rise must land in reset
  logic [2:0] ones_cnt;
  wire ones_full = (ones_cnt == 3'(mtap_pkg::TLR_COUNT - 1));
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ones_cnt <= 3'h0;
    end else if (rise) begin
      if (!tms) begin
        ones_cnt <= 3'h0;
      end else if (!ones_full) begin
        ones_cnt <= ones_cnt + 3'h1;
      end
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_tdo_hold_rise: assert property (@(posedge sys_clk) disable iff (srst)
    !fall |=> $stable(tdo) && $stable(tdo_oe))
    else $error("tdo changed without falling edge");
  a_state_rise: assert property (@(posedge sys_clk) disable iff (srst)
    !rise |=> $stable(state))
    else $error("state moved without rising edge");
  a_tlr_preset: assert property (@(posedge sys_clk) disable iff (srst)
    rise && to_tlr |=> active_ins == mtap_pkg::INS_IDCODE)
    else $error("instruction not preset on entering reset");
  a_ir_capture: assert property (@(posedge sys_clk) disable iff (srst)
    rise && state == mtap_pkg::ST_CAP_IR |=> ir_sh[1:0] == mtap_pkg::IR_CAPTURE)
    else $error("capture did not load 01");
  a_ir_shift: assert property (@(posedge sys_clk) disable iff (srst)
    rise && in_sh_ir |=> ir_sh == {$past(tdi), $past(ir_sh[2:1])})
    else $error("instruction shift lost a bit");
  a_ir_hold: assert property (@(posedge sys_clk) disable iff (srst)
    !(rise && (in_sh_ir || state == mtap_pkg::ST_CAP_IR))
    |=> $stable(ir_sh))
    else $error("instruction shifter moved outside capture or shift");
  a_ins_update: assert property (@(posedge sys_clk) disable iff (srst)
    !(rise && (state == mtap_pkg::ST_UPD_IR || to_tlr))
    |=> $stable(active_ins))
    else $error("instruction changed outside update");
  a_ins_apply: assert property (@(posedge sys_clk) disable iff (srst)
    rise && state == mtap_pkg::ST_UPD_IR |=> active_ins == $past(ir_sh))
    else $error("update did not apply shifted instruction");
  a_byp_shift: assert property (@(posedge sys_clk) disable iff (srst)
    rise && in_sh_dr && sel_byp |=> byp == $past(tdi))
    else $error("bypass did not take data in");
  a_byp_hold: assert property (@(posedge sys_clk) disable iff (srst)
    !(rise && (in_sh_dr || state == mtap_pkg::ST_CAP_DR))
    |=> $stable(byp))
    else $error("bypass stage moved outside capture or shift");
  a_id_capture: assert property (@(posedge sys_clk) disable iff (srst)
    rise && state == mtap_pkg::ST_CAP_DR |=> id_sh == mtap_pkg::ID_CODE_RST)
    else $error("id code not captured");
  a_id_shift: assert property (@(posedge sys_clk) disable iff (srst)
    rise && in_sh_dr && !sel_byp |=> id_sh == {$past(tdi), $past(id_sh[31:1])})
    else $error("id shift lost a bit");
  a_id_hold: assert property (@(posedge sys_clk) disable iff (srst)
    !(rise && (in_sh_dr || state == mtap_pkg::ST_CAP_DR))
    |=> $stable(id_sh))
    else $error("id register moved outside capture or shift");
  a_five_ones: assert property (@(posedge sys_clk) disable iff (srst)
    rise && tms && ones_full |=> state == mtap_pkg::ST_RESET)
    else $error("five high mode selects did not reset");
  a_reset_quiet: assert property (@(posedge sys_clk) disable iff (srst)
    state == mtap_pkg::ST_RESET |-> !tdo_oe)
    else $error("output enabled in reset state");
  // ----------------------------------------
  // output checks
  // ----------------------------------------
  a_oe_shift: assert property (@(posedge sys_clk) disable iff (srst)
    fall |=> tdo_oe == ($past(in_sh_ir) || $past(in_sh_dr)))
    else $error("output enable wrong for state");
  a_oe_where: assert property (@(posedge sys_clk) disable iff (srst)
    tdo_oe |-> state inside {mtap_pkg::ST_SH_DR, mtap_pkg::ST_EX1_DR,
                             mtap_pkg::ST_SH_IR, mtap_pkg::ST_EX1_IR})
    else $error("output enabled away from shifting");
  a_tdo_ir: assert property (@(posedge sys_clk) disable iff (srst)
    fall && in_sh_ir |=> tdo == $past(ir_sh[0]))
    else $error("tdo not instruction end bit");
  a_tdo_id: assert property (@(posedge sys_clk) disable iff (srst)
    fall && in_sh_dr && !sel_byp |=> tdo == $past(id_sh[0]))
    else $error("tdo not id end bit");
  a_tdo_byp: assert property (@(posedge sys_clk) disable iff (srst)
    fall && in_sh_dr && sel_byp |=> tdo == $past(byp))
    else $error("tdo not bypass bit");
endmodule : mtap_port
`default_nettype wire

// File: mtap_pkg.sv
// package for the memory test access port: states, instructions, widths
// assumes a single system clock; test clock arrives as a sampled pin
package mtap_pkg;
  // ----------------------------------------
  // controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR,
    ST_EX2_IR, ST_UPD_IR
  } mtap_state_e;
  // ----------------------------------------
  // instruction register, id code and reset constants
  // ----------------------------------------
  localparam int IR_W = 3;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam int ID_W = 32;
  // arbitrary identification value, not a real maker code
  localparam logic [31:0] ID_CODE_RST = 32'h0000_0001;
  localparam int TLR_COUNT = 5;
  localparam logic [2:0] SYNC_RST = 3'h7;
  // ----------------------------------------
  // pin group
  // ----------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } mtap_pins_s;
endpackage : mtap_pkg

// File: mtap_host.sv
// model of the board scan controller that drives the test pins
// assumes sys_clk runs free; tck moves only inside step
`timescale 1ns/1ns
`default_nettype none
module mtap_host (
  input wire logic sys_clk,
  input wire logic tdo,
  input wire logic tdo_oe,
  output var mtap_pkg::mtap_pins_s pins
);
  // pulled-up pins, tck parked high
  initial pins = 3'h7;
  // one tck period: fall, low 4, sample tdo at the rise, high 4
  task step(input logic m, input logic d, output logic o, output logic oe);
    pins.tck = 1'b0;
    pins.tms = m;
    pins.tdi = d;
    repeat (4) @(negedge sys_clk);
    // released output reads as the opposite of its last level
    o = tdo_oe ? tdo : ~tdo;
    oe = tdo_oe;
    pins.tck = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : step
endmodule : mtap_host
`default_nettype wire

// File: tb_memory_test_access_port.sv
// self-checking bench for the test access port
// assumes mtap_host as the far side; design instance mtap_port_i
`timescale 1ns/1ns
`default_nettype none
module tb_memory_test_access_port;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  mtap_pkg::mtap_pins_s pins;
  logic tdo;
  logic tdo_oe;
  logic [2:0] active_ins;
  int num_errors = 0;
  int comparisons = 0;
  logic o;
  logic oe;
  logic [31:0] w;
  always #4 sys_clk = ~sys_clk;
  mtap_port mtap_port_i (.sys_clk(sys_clk), .srst(srst), .pins(pins), .tdo(tdo),
    .tdo_oe(tdo_oe), .active_ins(active_ins));
  mtap_host mtap_host_i (.sys_clk(sys_clk), .tdo(tdo), .tdo_oe(tdo_oe), .pins(pins));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  // tms sequence, lsb first
  task walk(input logic [7:0] t, input int n);
    for (int i = 0; i < n; i++) mtap_host_i.step(t[i], 1'b1, o, oe);
  endtask : walk
  // shift n bits, last with tms high; result in w
  task shift(input logic [31:0] din, input int n);
    for (int i = 0; i < n; i++) begin
      mtap_host_i.step(i == n - 1, din[i], o, oe);
      w[i] = o;
      chk({31'h0, oe}, 32'h1);
    end
  endtask : shift
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    chk({31'h0, tdo_oe}, 32'h0);
    chk({29'h0, active_ins}, {29'h0, mtap_pkg::INS_IDCODE});
    repeat (20) @(negedge sys_clk);
    chk({31'h0, tdo_oe}, 32'h0);
  endtask : t_reset
  task t_idcode;
    walk(8'h02, 4);
    w = 32'h0;
    shift(32'h0, 32);
    chk(w, mtap_pkg::ID_CODE_RST);
    mtap_host_i.step(1'b1, 1'b1, o, oe);
    chk({31'h0, oe}, 32'h0);
    walk(8'h00, 1);
  endtask : t_idcode
  task t_ir(input logic [2:0] ins, input logic [2:0] old);
    walk(8'h03, 4);
    shift({29'h0, ins}, 3);
    chk({29'h0, w[2:0]}, {29'h0, old[2], mtap_pkg::IR_CAPTURE});
    chk({29'h0, active_ins}, {29'h0, old});
    walk(8'h01, 2);
    chk({29'h0, active_ins}, {29'h0, ins});
  endtask : t_ir
  task t_bypass;
    walk(8'h02, 4);
    shift(32'h0000_00B4, 9);
    chk({24'h0, w[8:1]}, 32'h0000_00B4);
    walk(8'h01, 2);
  endtask : t_bypass
  // five highs from the middle of a data shift
  task t_five;
    walk(8'h02, 4);
    walk(8'h1F, 5);
    chk({29'h0, active_ins}, {29'h0, mtap_pkg::INS_IDCODE});
    chk({31'h0, tdo_oe}, 32'h0);
  endtask : t_five
  task close_out;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    close_out;
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    repeat (3) @(negedge sys_clk);
    t_reset;
    t_idcode;
    t_ir(mtap_pkg::INS_BYPASS, mtap_pkg::INS_IDCODE);
    t_bypass;
    t_ir(3'h2, mtap_pkg::INS_BYPASS);
    t_bypass;
    t_five;
    t_idcode;
    close_out;
  end
endmodule : tb_memory_test_access_port
`default_nettype wire
